// file: verilog/tps_params.svh
// constants for the four-link pcm serial port
`ifndef TPS_PARAMS_SVH
`define TPS_PARAMS_SVH
`define TPS_LINKS      4
`define TPS_HCLK_MHZ   50
// register map, byte offsets inside one link's 16-byte block
`define TPS_ADDR_W     6
`define TPS_OFS_TXC1   4'h0
`define TPS_OFS_TXC2   4'h4
`define TPS_OFS_RXC    4'h8
`define TPS_OFS_STAT   4'hc
`define TPS_F_LINK     5:4
`define TPS_F_REG      3:0
// field positions
`define TPS_F_TXC1     7:0
`define TPS_F_GRP      7:6
`define TPS_F_DIR      4
`define TPS_F_SRC      2:0
`define TPS_F_RXC      9:0
`define TPS_F_RXERR    0
`define TPS_F_TXERR    1
`define TPS_F_RXBYTE   15:8
// frame geometry
`define TPS_T1_LAST    9'h0c0
`define TPS_BUS_LAST   9'h0ff
`define TPS_T1_SLOTS   5'h18
`define TPS_ISDN_CH    5'h17
`define TPS_SPC_ISDN   5'h1f
`define TPS_E1_SIG     5'h10
`define TPS_LAST_BIT   3'h7
`endif

// file: verilog/tps_pkg.sv
// types shared by the pcm serial port
`include "tps_params.svh"
package tps_pkg;
   typedef struct packed {
      logic [1:0] grp;
      logic       en;
      logic       e1;
      logic       fixbus;
      logic       clk2048;
      logic       spaced;
      logic       isdn;
      logic       clk_pol;
      logic       sync_pol;
   } tps_cfg_type;
   typedef struct packed {
      logic       dir;
      logic [2:0] src;
   } tps_src_type;
   typedef struct packed {
      logic [8:0] bitc;
      logic       phase;
      logic [7:0] sh;
      logic       prev;
      logic       err;
   } tps_dir_type;
   typedef struct packed {
      logic [3:0] rx_clk;
      logic [3:0] rx_sync;
      logic [3:0] sdi;
      logic [3:0] tx_clk;
      logic [3:0] tx_sync;
      logic [3:0] ref_clk;
   } tps_pin_in_type;
   typedef struct packed {
      logic [3:0] sdo;
      logic [3:0] sdo_oe;
      logic [3:0] tx_clk;
      logic [3:0] tx_clk_oe;
      logic [3:0] tx_sync;
      logic [3:0] tx_sync_oe;
   } tps_pin_out_type;
   typedef struct packed {
      logic [3:0][7:0] rx_byte;
      logic [3:0]      rx_valid;
      logic [3:0]      tx_req;
      logic [3:0][1:0] tx_grp;
      logic [3:0][1:0] rx_grp;
   } tps_user_type;
   typedef struct packed {
      tps_cfg_type [3:0] txc;
      tps_cfg_type [3:0] rxc;
      tps_src_type [3:0] tsrc;
      tps_dir_type [3:0] tx;
      tps_dir_type [3:0] rx;
      tps_pin_in_type    s1;
      tps_pin_in_type    s2;
      tps_pin_out_type   po;
      tps_user_type      uo;
      logic [31:0]       hrdata;
      logic              wr;
      logic [5:0]        wa;
      logic              rdy;
      logic              hresp;
   } tps_state_type;
endpackage : tps_pkg

// file: verilog/tps_port.sv
// four-link t1/e1 pcm serial port with ahb-lite registers
`timescale 1ns/10ps
`include "tps_params.svh"
module tps_port #(
   parameter int NLINK = `TPS_LINKS
) (
   // clock and reset
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   // ahb-lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output      logic                   hreadyout,
   output      logic [31:0]            hrdata,
   output      logic                   hresp,
   // framer pins
   input  wire tps_pkg::tps_pin_in_type  pins_i,
   output      tps_pkg::tps_pin_out_type pins_o,
   // cell side
   input  wire logic [3:0][7:0]        tx_byte,
   output      tps_pkg::tps_user_type  user_o
);
   if (NLINK != `TPS_LINKS) begin : g_chk
      $error("tps_port serves exactly four links");
   end

   tps_pkg::tps_state_type st_q;
   tps_pkg::tps_state_type nx;
   tps_pkg::tps_cfg_type   c;
   tps_pkg::tps_src_type   s;
   tps_pkg::tps_dir_type   d;
   logic [1:0]             l;
   logic [31:0]            rd;
   logic [9:0]             adv;
   logic                   ok;
   logic                   out;
   logic                   srcl;
   logic                   pol;
   logic                   spol;
   logic                   lvl;
   logic                   act;
   logic                   pay;

   ////////////////////////////////////////////////////////////////////////
   // frame geometry

   // native t1 is the only frame that is not 32 slots of 8 bits
   function automatic logic native(tps_pkg::tps_cfg_type f);
      return !f.e1 && !f.fixbus && !f.clk2048;
   endfunction : native

   function automatic logic [2:0] bofs(tps_pkg::tps_cfg_type f,
                                       logic [8:0] b);
      return native(f) ? 3'(b - 9'h001) : b[2:0];
   endfunction : bofs

   function automatic logic payload(tps_pkg::tps_cfg_type f,
                                    logic [8:0] b);
      logic [4:0] sl;
      logic [4:0] ch;
      sl = b[7:3];
      ch = 5'((b - 9'h001) >> 3);
      if (f.e1)
         payload = sl != 5'h00 && sl != `TPS_E1_SIG;
      else if (native(f))
         payload = b != 9'h000 && !(f.isdn && ch == `TPS_ISDN_CH);
      else if (f.spaced)
         payload = sl[1:0] != 2'h0 && !(f.isdn && sl == `TPS_SPC_ISDN);
      else
         payload = sl < `TPS_T1_SLOTS && !(f.isdn && sl == `TPS_ISDN_CH);
   endfunction : payload

   // next bit index and sync error flag; a sync forces bit 0
   // wrap on any index past the end, so a counter left high by a
   // switch from a 256-bit to a 193-bit frame cannot run on to 511
   function automatic logic [9:0] advance(tps_pkg::tps_cfg_type f,
                                          logic [8:0] b, logic syn);
      logic [8:0] n;
      logic       e;
      n = (b >= (native(f) ? `TPS_T1_LAST : `TPS_BUS_LAST)) ?
          9'h000 : 9'(b + 9'h001);
      e = 1'b0;
      if (syn) begin
         e = n != 9'h000;
         n = 9'h000;
      end
      return {e, n};
   endfunction : advance

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      nx = st_q;
      c = '0;
      s = '0;
      d = '0;
      l = '0;
      rd = '0;
      adv = '0;
      ok = 1'b0;
      out = 1'b0;
      srcl = 1'b0;
      pol = 1'b0;
      spol = 1'b0;
      lvl = 1'b0;
      act = 1'b0;
      pay = 1'b0;
      nx.uo.rx_valid = '0;
      nx.uo.tx_req = '0;
      nx.s1 = pins_i;
      nx.s2 = st_q.s1;
      // data phase of a write
      if (st_q.wr) begin
         l = st_q.wa[`TPS_F_LINK];
         case (st_q.wa[`TPS_F_REG])
            `TPS_OFS_TXC1: nx.txc[l][`TPS_F_TXC1] = hwdata[`TPS_F_TXC1];
            `TPS_OFS_TXC2: begin
               nx.txc[l].grp = hwdata[`TPS_F_GRP];
               nx.tsrc[l].dir = hwdata[`TPS_F_DIR];
               nx.tsrc[l].src = hwdata[`TPS_F_SRC];
            end
            `TPS_OFS_RXC: nx.rxc[l] = hwdata[`TPS_F_RXC];
            `TPS_OFS_STAT: begin
               if (hwdata[`TPS_F_RXERR])
                  nx.rx[l].err = 1'b0;
               if (hwdata[`TPS_F_TXERR])
                  nx.tx[l].err = 1'b0;
            end
            default: ;
         endcase
      end
      // address phase; control register reads see a write from the cycle before, status reads do not
      nx.wr = 1'b0;
      if (hsel && htrans[1] && hready) begin
         ok = haddr[31:`TPS_ADDR_W] == '0;
         nx.wr = hwrite && ok;
         nx.wa = haddr[`TPS_ADDR_W-1:0];
         l = haddr[`TPS_F_LINK];
         case (haddr[`TPS_F_REG])
            `TPS_OFS_TXC1: rd[`TPS_F_TXC1] = nx.txc[l][`TPS_F_TXC1];
            `TPS_OFS_TXC2: begin
               rd[`TPS_F_GRP] = nx.txc[l].grp;
               rd[`TPS_F_DIR] = nx.tsrc[l].dir;
               rd[`TPS_F_SRC] = nx.tsrc[l].src;
            end
            `TPS_OFS_RXC: rd[`TPS_F_RXC] = nx.rxc[l];
            `TPS_OFS_STAT: begin
               rd[`TPS_F_RXERR] = st_q.rx[l].err;
               rd[`TPS_F_TXERR] = st_q.tx[l].err;
               rd[`TPS_F_RXBYTE] = st_q.uo.rx_byte[l];
            end
            default: ;
         endcase
         if (!hwrite)
            nx.hrdata = ok ? rd : '0;
      end
      // links; error sets come after the clears so a set wins
      for (int i = 0; i < `TPS_LINKS; i++) begin
         // transmit serializer
         c = st_q.txc[i];
         s = st_q.tsrc[i];
         out = c.en && (c.fixbus == s.dir);
         srcl = s.src[2] ? st_q.s2.ref_clk[s.src[1:0]] :
                           st_q.s2.rx_clk[s.src[1:0]];
         pol = c.clk_pol && !c.fixbus;
         spol = c.sync_pol && !c.fixbus;
         lvl = (out ? srcl : st_q.s2.tx_clk[i]) ^ pol;
         d = nx.tx[i];
         d.prev = lvl;
         act = 1'b0;
         if (c.en && lvl && !st_q.tx[i].prev) begin
            d.phase = ~d.phase;
            act = !c.fixbus || st_q.tx[i].phase;
         end
         if (act) begin
            adv = advance(c, d.bitc,
                          !out && (st_q.s2.tx_sync[i] ^ spol));
            d.err = d.err | adv[9];
            d.bitc = adv[8:0];
            pay = payload(c, adv[8:0]);
            if (pay && bofs(c, adv[8:0]) == 3'h0) begin
               nx.po.sdo[i] = tx_byte[i][7];
               d.sh = {tx_byte[i][6:0], 1'b0};
               nx.uo.tx_req[i] = 1'b1;
            end else begin
               nx.po.sdo[i] = d.sh[7];
               d.sh = {d.sh[6:0], 1'b0};
            end
            nx.po.sdo_oe[i] = pay;
         end
         if (!c.en)
            nx.po.sdo_oe[i] = 1'b0;
         nx.po.tx_clk[i] = srcl;
         nx.po.tx_clk_oe[i] = out;
         // one pulse per frame at this link's bit 0, timed by the clock that src selects when driven
         nx.po.tx_sync[i] = (d.bitc == 9'h000) ^ spol;
         nx.po.tx_sync_oe[i] = out;
         nx.tx[i] = d;
         nx.uo.tx_grp[i] = c.grp;
         // receive assembler; clock and sync only ever inputs
         c = st_q.rxc[i];
         pol = c.clk_pol && !c.fixbus;
         spol = c.sync_pol && !c.fixbus;
         lvl = st_q.s2.rx_clk[i] ^ pol;
         d = nx.rx[i];
         d.prev = lvl;
         act = 1'b0;
         if (c.en && lvl && !st_q.rx[i].prev) begin
            d.phase = ~d.phase;
            act = !c.fixbus || st_q.rx[i].phase;
         end
         if (act) begin
            adv = advance(c, d.bitc, st_q.s2.rx_sync[i] ^ spol);
            d.err = d.err | adv[9];
            d.bitc = adv[8:0];
            if (payload(c, adv[8:0])) begin
               d.sh = {d.sh[6:0], st_q.s2.sdi[i]};
               if (bofs(c, adv[8:0]) == `TPS_LAST_BIT) begin
                  nx.uo.rx_byte[i] = d.sh;
                  nx.uo.rx_valid[i] = 1'b1;
               end
            end
         end
         nx.rx[i] = d;
         nx.uo.rx_grp[i] = c.grp;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
         st_q.rdy <= 1'b1;
      end else begin
         st_q <= nx;
      end
   end

   assign hreadyout = st_q.rdy;
   assign hrdata = st_q.hrdata;
   assign hresp = st_q.hresp;
   assign pins_o = st_q.po;
   assign user_o = st_q.uo;

   ////////////////////////////////////////////////////////////////////////
   // checks on link 0

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_wr_c1;
      hsel && htrans[1] && hready && hwrite && haddr == 32'h0000_0000;
   endsequence
   // data phase ends at the edge where the bus is ready
   sequence s_data;
      hready;
   endsequence

   property p_mode_write;
      logic [31:0] w;
      s_wr_c1 ##1 (s_data, w = hwdata) |=>
         st_q.txc[0].e1 == w[6] && st_q.txc[0].fixbus == w[5];
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("mode bits not taken from write");

   property p_off_float;
      !st_q.txc[0].en ##1 !st_q.txc[0].en |-> !pins_o.sdo_oe[0] &&
         !pins_o.tx_clk_oe[0] && !pins_o.tx_sync_oe[0];
   endproperty
   a_off_float: assert property (p_off_float)
      else $error("disabled link drives a pin");

   // slot checks only right after a bit edge: oe and slot move together
   property p_e1_skip;
      st_q.txc[0].e1 && $stable(st_q.txc[0]) &&
      $changed(st_q.tx[0].bitc) &&
      (st_q.tx[0].bitc[7:3] == 5'h00 || st_q.tx[0].bitc[7:3] == 5'h10)
      |-> !pins_o.sdo_oe[0];
   endproperty
   a_e1_skip: assert property (p_e1_skip)
      else $error("e1 slot 0 or 16 driven");

   property p_spaced_float;
      !st_q.txc[0].e1 && st_q.txc[0].spaced && $stable(st_q.txc[0]) &&
      (st_q.txc[0].fixbus || st_q.txc[0].clk2048) &&
      $changed(st_q.tx[0].bitc) &&
      st_q.tx[0].bitc[4:3] == 2'h0 |-> !pins_o.sdo_oe[0];
   endproperty
   a_spaced_float: assert property (p_spaced_float)
      else $error("spaced unused slot driven");

   property p_group_float;
      !st_q.txc[0].e1 && !st_q.txc[0].spaced && $stable(st_q.txc[0]) &&
      $changed(st_q.tx[0].bitc) &&
      st_q.txc[0].fixbus && st_q.tx[0].bitc[7:3] >= 5'h18
      |-> !pins_o.sdo_oe[0];
   endproperty
   a_group_float: assert property (p_group_float)
      else $error("grouped unused slot driven");

   property p_t1_len;
      native(st_q.txc[0]) && $stable(st_q.txc[0]) && st_q.txc[0].en &&
      $changed(st_q.tx[0].bitc)
      |-> st_q.tx[0].bitc <= 9'h0c0 &&
          (st_q.tx[0].bitc != 9'h000 || !pins_o.sdo_oe[0]);
   endproperty
   a_t1_len: assert property (p_t1_len)
      else $error("native t1 frame too long or framing bit driven");

   property p_dir;
      st_q.txc[0].en && !st_q.txc[0].fixbus && !st_q.tsrc[0].dir
      |=> pins_o.tx_clk_oe[0] && pins_o.tx_sync_oe[0];
   endproperty
   a_dir: assert property (p_dir)
      else $error("generic mode tx clock not driven");

   property p_sync_err;
      $rose(st_q.rx[0].err) |-> $past(st_q.s2.rx_sync[0], 1) != 1'b0 ||
         $past(st_q.rxc[0].sync_pol, 1);
   endproperty
   a_sync_err: assert property (p_sync_err)
      else $error("sync error without a sync");

   property p_rx_pulse;
      user_o.rx_valid[0] |=> !user_o.rx_valid[0] [*8];
   endproperty
   a_rx_pulse: assert property (p_rx_pulse)
      else $error("rx byte strobes too close");

   property p_tx_frame_sync_pulse;
      pins_o.tx_sync_oe[0] && !st_q.txc[0].sync_pol && $rose(pins_o.tx_sync[0])
      |-> st_q.tx[0].bitc == 9'h000;
   endproperty
   a_tx_frame_sync_pulse: assert property (p_tx_frame_sync_pulse)
      else $error("tx sync pulse not at frame start");
endmodule : tps_port

// file: tb/tps_framer.sv
// framer model: bit clock, frame sync and a fixed byte stream
`timescale 1ns/10ps
module tps_framer (
   // frame shape chosen by the bench
   input  wire logic [8:0] nbits,
   input  wire logic       two_clk,
   input  wire logic       clk_pol,
   input  wire logic       sync_pol,
   input  wire logic       glitch,
   // link pins toward the device
   output      logic       bit_clk,
   output      logic       sync,
   output      logic       data
);
   logic       raw;
   logic [9:0] clks = 10'h000;
   logic [9:0] flen;
   logic [8:0] b;
   logic [8:0] k;
   localparam logic [7:0] byte_pat = 8'ha5;
   initial begin
      raw = 1'b0;
      forever #80 raw = ~raw;
   end
   // a real framer keeps its bit clock running between frames
   assign bit_clk = raw ^ clk_pol;
   assign flen = two_clk ? {nbits, 1'b0} : {1'b0, nbits};
   assign b = two_clk ? clks[9:1] : clks[8:0];
   // in 193-bit frames bit 0 is the framing bit, payload starts at bit 1
   assign k = (nbits == 9'h0c1) ? b - 9'h001 : b;
   // glitch plants a stray pulse mid-frame on purpose
   assign sync = ((b == 9'h000) | (glitch & (b == 9'h064))) ^ sync_pol;
   // msb first: offset 0 of each slot carries bit 7
   assign data = byte_pat[3'h7 - k[2:0]];
   // levels move on the inactive edge so every active edge sees them settled
   always @(negedge raw) begin
      clks <= (clks + 10'h001 >= flen) ? 10'h000 : clks + 10'h001;
   end
endmodule : tps_framer

// file: tb/tb.sv
// self-checking bench for the four-link pcm serial port
`timescale 1ns/10ps
module tb;
   typedef struct packed {
      logic [7:0] txc;
      logic [7:0] rxc;
      logic       dir;
      logic [8:0] nb;
      logic       two;
      logic [4:0] ptx;
      logic [4:0] prx;
   } tps_row_type;
   logic                     hclk;
   logic                     hresetn;
   logic                     hsel;
   logic [31:0]              haddr;
   logic [1:0]               htrans;
   logic                     hwrite;
   logic [2:0]               hsize;
   logic [31:0]              hwdata;
   logic                     hreadyout;
   logic [31:0]              hrdata;
   logic                     hresp;
   tps_pkg::tps_pin_in_type  pins_i;
   tps_pkg::tps_pin_out_type pins_o;
   logic [3:0][7:0]          tx_byte;
   tps_pkg::tps_user_type    user_o;
   tps_row_type              cur;
   logic                     glitch;
   logic                     fr_clk;
   logic                     fr_sync;
   logic                     fr_data;
   logic                     win;
   logic                     clr;
   logic                     ts;
   logic                     ts_q;
   logic [15:0]              n_req;
   logic [15:0]              n_oe;
   logic [15:0]              n_val;
   logic [15:0]              n_bad;
   logic [15:0]              n_sync;
   logic [15:0]              n_one;
   logic [15:0]              n_tck;
   logic                     tck_q;
   int                       mismatches;
   int                       num_checks;
   logic [31:0]              msk [3] = '{32'h0ff, 32'h0d7, 32'h3ff};
   // tx ctrl1, rx ctrl, dir, frame bits, two clocks per bit, tx and rx slots
   tps_row_type              tbl [10] = '{
      {8'h90, 8'h90, 1'b0, 9'h100, 1'b0, 5'h18, 5'h18},
      {8'h98, 8'h98, 1'b0, 9'h100, 1'b0, 5'h18, 5'h18},
      {8'h94, 8'h90, 1'b0, 9'h100, 1'b0, 5'h17, 5'h18},
      {8'h9f, 8'h9f, 1'b0, 9'h100, 1'b0, 5'h17, 5'h17},
      {8'h80, 8'h84, 1'b1, 9'h0c1, 1'b0, 5'h18, 5'h17},
      {8'hc4, 8'hc0, 1'b1, 9'h100, 1'b0, 5'h1e, 5'h1e},
      {8'he0, 8'he0, 1'b1, 9'h100, 1'b1, 5'h1e, 5'h1e},
      {8'hb8, 8'hb8, 1'b0, 9'h100, 1'b1, 5'h18, 5'h18},
      {8'hb4, 8'hb4, 1'b1, 9'h100, 1'b1, 5'h17, 5'h17},
      {8'h10, 8'h10, 1'b0, 9'h100, 1'b0, 5'h00, 5'h00}};
   ////////////////////////////////////////////////////////////////////////
   // the tx clock and sync pins carry the device when it drives them
   assign pins_i = {{4{fr_clk}}, {4{fr_sync}}, {4{fr_data}},
      (pins_o.tx_clk_oe & pins_o.tx_clk) | (~pins_o.tx_clk_oe & {4{fr_clk}}),
      (pins_o.tx_sync_oe & pins_o.tx_sync)
      | (~pins_o.tx_sync_oe & {4{fr_sync}}), {4{fr_clk}}};
   assign ts = pins_o.tx_sync[0] ^ cur.txc[0];
   tps_port tps_port_inst (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hreadyout),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .hresp     (hresp),
      .pins_i    (pins_i),
      .pins_o    (pins_o),
      .tx_byte   (tx_byte),
      .user_o    (user_o)
   );
   tps_framer tps_framer_inst (
      .nbits    (cur.nb),
      .two_clk  (cur.two),
      .clk_pol  (cur.rxc[1]),
      .sync_pol (cur.rxc[0]),
      .glitch   (glitch),
      .bit_clk  (fr_clk),
      .sync     (fr_sync),
      .data     (fr_data)
   );
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   // counting over exactly one frame period makes the phase irrelevant
   always @(posedge hclk) begin
      ts_q <= ts;
      tck_q <= pins_o.tx_clk[0];
      if (clr) begin
         {n_req, n_oe, n_val, n_bad, n_sync, n_one, n_tck} <= 112'h0;
      end else if (win) begin
         n_one  <= n_one + 16'(pins_o.sdo_oe[0] & pins_o.sdo[0]);
         n_tck  <= n_tck + 16'(pins_o.tx_clk[0] & ~tck_q
                              & pins_o.tx_clk_oe[0]);
         n_req  <= n_req + 16'(user_o.tx_req[0]);
         n_oe   <= n_oe + 16'(pins_o.sdo_oe[0]);
         n_val  <= n_val + 16'(user_o.rx_valid[0]);
         n_sync <= n_sync + 16'(ts & ~ts_q & pins_o.tx_sync_oe[0]);
         if (user_o.rx_valid[0] === 1'b1)
            n_bad <= n_bad + 16'(user_o.rx_byte[0] !== 8'ha5);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      #1960000;
      mismatches++;
      report_and_stop();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      tps_row_type r;
      int          w;
      logic [31:0] d;
      logic        o;
      {hresetn, hsel, haddr, htrans, hwrite, hwdata} = 69'h0;
      hsize = 3'h2;
      tx_byte = {4{8'h3c}};
      cur = tbl[0];
      {glitch, win, clr} = 3'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         r = tbl[i];
         cur <= r;
         ahb(1'b1, 32'h0, {24'h0, r.txc}, d);
         // rows 0 to 7 each pick another of the eight clock sources, rows 8 and 9 reuse sources 0 and 1
         ahb(1'b1, 32'h4, {24'h0, 2'(i), 1'b0, r.dir, 1'b0, 3'(i)}, d);
         ahb(1'b1, 32'h8, {22'h0, ~2'(i), r.rxc}, d);
         w = int'(r.nb) * (r.two ? 16 : 8);
         repeat (2 * w) @(posedge hclk);
         clr <= 1'b1;
         @(posedge hclk);
         clr <= 1'b0;
         win <= 1'b1;
         repeat (w) @(posedge hclk);
         win <= 1'b0;
         @(posedge hclk);
         // generic drives clock and sync when dir is 0, fixed bus when 1
         o = r.txc[7] & ~(r.txc[5] ^ r.dir);
         chk(n_req, r.ptx);
         chk(n_oe, int'(r.ptx) * (r.two ? 128 : 64));
         // tx byte 8'h3c has four ones, each standing one bit time
         chk(n_one, int'(r.ptx) * (r.two ? 64 : 32));
         chk(n_tck, o ? int'(r.nb) * (r.two ? 2 : 1) : 0);
         chk(n_val, r.prx);
         chk(n_bad, 0);
         chk(n_sync, o);
         chk({pins_o.tx_clk_oe[0], pins_o.tx_sync_oe[0]}, {o, o});
         chk({user_o.tx_grp[0], user_o.rx_grp[0]}, {2'(i), ~2'(i)});
      end
      // second reset while traffic runs
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({hreadyout, hresp, pins_o.sdo_oe, pins_o.tx_clk_oe,
           pins_o.tx_sync_oe}, 32'h2000);
      chk({user_o.tx_grp, user_o.rx_grp, user_o.tx_req}, 0);
      hresetn <= 1'b1;
      for (int a = 0; a < 64; a += 4) begin
         ahb(1'b0, 32'(a), 32'h0, d);
         chk(d, 0);
      end
      // unmapped space swallows writes and reads back zero
      ahb(1'b1, 32'h40, 32'hffffffff, d);
      ahb(1'b0, 32'h40, 32'h0, d);
      chk(d, 0);
      ahb(1'b0, 32'h0, 32'h0, d);
      chk(d, 0);
      for (int k = 0; k < 3; k++) begin
         ahb(1'b1, 32'h30 + 32'(4 * k), 32'hffffffff, d);
         ahb(1'b0, 32'h30 + 32'(4 * k), 32'h0, d);
         chk(d, msk[k]);
      end
      chk({user_o.tx_grp[3], user_o.rx_grp[3]}, 32'hf);
      // a stray sync pulse must raise the rx sync error flag
      cur <= tbl[0];
      ahb(1'b1, 32'h8, 32'h090, d);
      repeat (4096) @(posedge hclk);
      ahb(1'b1, 32'hc, 32'h3, d);
      repeat (2048) @(posedge hclk);
      ahb(1'b0, 32'hc, 32'h0, d);
      chk(d, 32'ha500);
      glitch <= 1'b1;
      repeat (2048) @(posedge hclk);
      ahb(1'b0, 32'hc, 32'h0, d);
      chk(d[0], 1);
      report_and_stop();
   end
endmodule : tb
